/* File: hw/ebpfg_top.sv */
// eight-bit port f: apb register file, pin muxing, boot strap capture
// assumes synchronous active-high reset and a zero-wait apb master;
// pins are split into in, out and enable, the pad ring resolves them
//
// Local design decision: the APB interface to the registers.

`timescale 1ns/10ps

// Contract
// - eight bits, bit 0 output only, bits 7..1 bidirectional each.
// - a pin may carry bus, interrupt, timer or strap functions.
// - after reset bits 7..1 are port bits with input, drive, pull off.
// - after reset bit 0 is an output with drive off and pull-up on.
// - three select registers, all zero means port, a one picks alt.
// - while reset is held bit 0 has input and pull-up enabled.
// - at reset release bit 0 high means flash boot, low boot rom.
// - outside stop, an enabled input feeds its interrupt line.
// - registers decode at the listed offsets from the port base.
// - data bits 31..8 read zero, bits 7..0 are the port data.
module ebpfg_top #(
    parameter int unsigned PORT_W   = ebpfg_pkg::PORT_W,
    parameter int unsigned SYNC_LEN = ebpfg_pkg::SYNC_LEN
) (
    // clock and reset
    input  wire logic        MCLK,
    input  wire logic        SYS_RST,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic [3:0]  PSTRB,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // pads
    input  wire logic [7:0]  PF_IN,
    output logic      [7:0]  PF_OUT,
    output logic      [7:0]  PF_OE,
    output logic      [7:0]  PF_PU,
    output logic      [7:0]  PF_IBE,
    // external bus function
    input  wire logic [7:0]  ALT_BUS_OUT,
    input  wire logic [7:0]  ALT_BUS_OE,
    // interrupt and timer inputs
    input  wire logic        STOP_MODE,
    output logic      [7:0]  INT_LINE,
    output logic      [7:0]  TMR_IN,
    // boot strap
    output logic             BOOT_FLASH,
    output logic             BOOT_VALID
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    generate
        if (PORT_W != ebpfg_pkg::PORT_W) begin : g_chk_w
            $error("ebpfg_top: only an eight-bit port is served");
        end
        if (SYNC_LEN < 2) begin : g_chk_s
            $error("ebpfg_top: SYNC_LEN below 2");
        end
    endgenerate

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [7:0] pin_data_reg;
    logic [7:0] output_drive_ctrl_reg;
    logic [7:0] alt_select_one_reg;
    logic [7:0] alt_select_two_reg;
    logic [7:0] alt_select_three_reg;
    logic [7:0] open_drain_reg;
    logic [7:0] pullup_reg;
    logic [7:0] input_buffer_reg;

    // ------------------------------------------------------------------
    // internal signals
    // ------------------------------------------------------------------
    logic        setup_ph;
    logic        wr_acc;
    logic        addr_hit;
    logic        lane0_wr;
    logic [7:0]  wr_byte;
    logic [7:0]  rd_byte;
    logic [31:0] prdata_reg;
    logic        err_reg;
    logic [7:0]  pin_lvl;
    logic [7:0]  port_mode;
    logic [7:0]  drv_en;
    logic [7:0]  drv_val;
    logic [7:0]  ibe_reg;
    logic [7:0]  pu_reg;
    logic [7:0]  int_reg;
    logic [7:0]  tmr_reg;
    logic        strap_reg;
    logic        boot_flash_reg;
    logic        boot_valid_reg;
    ebpfg_pkg::ebpfg_phase_t phase_reg;

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    assign setup_ph = PSEL & ~PENABLE;
    assign wr_acc   = PSEL & PENABLE & PWRITE;
    assign lane0_wr = wr_acc & PSTRB[0] & addr_hit;
    assign wr_byte  = PWDATA[7:0];

    always_comb begin
        addr_hit = 1'b0;
        if (PADDR[1:0] == ebpfg_pkg::ALIGN_OK) begin
            case (PADDR)
                ebpfg_pkg::OFS_DATA: addr_hit = 1'b1;
                ebpfg_pkg::OFS_CTRL: addr_hit = 1'b1;
                ebpfg_pkg::OFS_FR1:  addr_hit = 1'b1;
                ebpfg_pkg::OFS_FR2:  addr_hit = 1'b1;
                ebpfg_pkg::OFS_FR3:  addr_hit = 1'b1;
                ebpfg_pkg::OFS_OD:   addr_hit = 1'b1;
                ebpfg_pkg::OFS_PUP:  addr_hit = 1'b1;
                ebpfg_pkg::OFS_IE:   addr_hit = 1'b1;
                default:             addr_hit = 1'b0;
            endcase
        end
    end

    // zero wait: the error flag is latched in setup with the read data
    assign PREADY  = 1'b1;
    assign PSLVERR = err_reg & PSEL & PENABLE;
    assign PRDATA  = prdata_reg;

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    always_comb begin
        rd_byte = ebpfg_pkg::RST_ZERO;
        case (PADDR)
            // enabled bits show the pin level
            ebpfg_pkg::OFS_DATA:
                rd_byte = (pin_lvl & input_buffer_reg)
                        | (pin_data_reg & ~input_buffer_reg);
            ebpfg_pkg::OFS_CTRL: rd_byte = output_drive_ctrl_reg;
            ebpfg_pkg::OFS_FR1:  rd_byte = alt_select_one_reg;
            ebpfg_pkg::OFS_FR2:  rd_byte = alt_select_two_reg;
            ebpfg_pkg::OFS_FR3:  rd_byte = alt_select_three_reg;
            ebpfg_pkg::OFS_OD:   rd_byte = open_drain_reg;
            ebpfg_pkg::OFS_PUP:  rd_byte = pullup_reg;
            ebpfg_pkg::OFS_IE:   rd_byte = input_buffer_reg;
            default:             rd_byte = ebpfg_pkg::RST_ZERO;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            prdata_reg <= '0;
            err_reg    <= 1'b0;
        end else if (setup_ph) begin
            prdata_reg <= (!PWRITE && addr_hit) ? {24'h000000, rd_byte}
                                                : 32'h00000000;
            err_reg    <= ~addr_hit;
        end
    end

    // ------------------------------------------------------------------
    // data register
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            pin_data_reg <= ebpfg_pkg::RST_ZERO;
        end else if (lane0_wr && PADDR == ebpfg_pkg::OFS_DATA) begin
            pin_data_reg <= wr_byte & ebpfg_pkg::MASK_ALL;
        end
    end

    // ------------------------------------------------------------------
    // output control
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            // bit 0 drive off after reset
            output_drive_ctrl_reg <= ebpfg_pkg::RST_ZERO;
        end else if (lane0_wr && PADDR == ebpfg_pkg::OFS_CTRL) begin
            output_drive_ctrl_reg <= wr_byte & ebpfg_pkg::MASK_ALL;
        end
    end

    // ------------------------------------------------------------------
    // function selects
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            alt_select_one_reg <= ebpfg_pkg::RST_ZERO;
        end else if (lane0_wr && PADDR == ebpfg_pkg::OFS_FR1) begin
            alt_select_one_reg <= wr_byte & ebpfg_pkg::MASK_FR1;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            alt_select_two_reg <= ebpfg_pkg::RST_ZERO;
        end else if (lane0_wr && PADDR == ebpfg_pkg::OFS_FR2) begin
            alt_select_two_reg <= wr_byte & ebpfg_pkg::MASK_FR2;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            alt_select_three_reg <= ebpfg_pkg::RST_ZERO;
        end else if (lane0_wr && PADDR == ebpfg_pkg::OFS_FR3) begin
            alt_select_three_reg <= wr_byte & ebpfg_pkg::MASK_FR3;
        end
    end

    // ------------------------------------------------------------------
    // open drain, pull-up, input enable
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            open_drain_reg <= ebpfg_pkg::RST_ZERO;
        end else if (lane0_wr && PADDR == ebpfg_pkg::OFS_OD) begin
            open_drain_reg <= wr_byte & ebpfg_pkg::MASK_ALL;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            // bit 0 pull-up on, others off
            pullup_reg <= ebpfg_pkg::RST_PUP;
        end else if (lane0_wr && PADDR == ebpfg_pkg::OFS_PUP) begin
            pullup_reg <= wr_byte & ebpfg_pkg::MASK_ALL;
        end
    end

    // bit 0 is output only, so its input enable is not writable
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            input_buffer_reg <= ebpfg_pkg::RST_ZERO;
        end else if (lane0_wr && PADDR == ebpfg_pkg::OFS_IE) begin
            input_buffer_reg <= wr_byte & ebpfg_pkg::MASK_IE;
        end
    end

    // ------------------------------------------------------------------
    // pin mux
    // ------------------------------------------------------------------
    // all selects zero means port
    assign port_mode = ~(alt_select_one_reg | alt_select_two_reg
                       | alt_select_three_reg);

    // overlapping selects are not resolved; port loses, bus output wins
    always_comb begin
        // bus function drives from the bus master
        drv_en  = (port_mode & output_drive_ctrl_reg)
                | (alt_select_one_reg & ALT_BUS_OE);
        drv_val = (port_mode & pin_data_reg)
                | (alt_select_one_reg & ALT_BUS_OUT);
    end

    genvar gi;
    generate
        for (gi = 0; gi < ebpfg_pkg::PORT_W; gi++) begin : g_pin
            ebpfg_pin_cell #(
                .SYNC_LEN (SYNC_LEN)
            ) u_cell (
                .clk     (MCLK),
                .rst     (SYS_RST),
                .pad_in  (PF_IN[gi]),
                .pad_out (PF_OUT[gi]),
                .pad_oe  (PF_OE[gi]),
                .drv_en  (drv_en[gi]),
                .drv_val (drv_val[gi]),
                .od_sel  (open_drain_reg[gi]),
                .pin_lvl (pin_lvl[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // pad controls
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            // strap input and pull-up on while held
            ibe_reg <= ebpfg_pkg::IBE_HELD;
            pu_reg  <= ebpfg_pkg::RST_PUP;
        end else begin
            ibe_reg <= input_buffer_reg;
            pu_reg  <= pullup_reg;
        end
    end

    assign PF_IBE = ibe_reg;
    assign PF_PU  = pu_reg;

    // ------------------------------------------------------------------
    // interrupt and timer inputs
    // ------------------------------------------------------------------
    // select bits do not gate interrupts, so unused sources must be off
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            int_reg <= ebpfg_pkg::RST_ZERO;
            tmr_reg <= ebpfg_pkg::RST_ZERO;
        end else begin
            int_reg <= STOP_MODE ? ebpfg_pkg::RST_ZERO
                                 : (pin_lvl & input_buffer_reg);
            tmr_reg <= pin_lvl & input_buffer_reg & alt_select_three_reg;
        end
    end

    assign INT_LINE = int_reg;
    assign TMR_IN   = tmr_reg;

    // ------------------------------------------------------------------
    // boot strap capture
    // ------------------------------------------------------------------
    // the strap is sampled every held cycle; the last sample wins
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            phase_reg <= ebpfg_pkg::PH_HELD;
        end else begin
            case (phase_reg)
                ebpfg_pkg::PH_HELD: phase_reg <= ebpfg_pkg::PH_RUN;
                ebpfg_pkg::PH_RUN:  phase_reg <= ebpfg_pkg::PH_RUN;
                default:            phase_reg <= ebpfg_pkg::PH_HELD;
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            strap_reg <= pin_lvl[ebpfg_pkg::STRAP_BIT];
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            boot_flash_reg <= 1'b0;
            boot_valid_reg <= 1'b0;
        end else if (phase_reg == ebpfg_pkg::PH_HELD) begin
            boot_flash_reg <= strap_reg;
            boot_valid_reg <= 1'b1;
        end
    end

    assign BOOT_FLASH = boot_flash_reg;
    assign BOOT_VALID = boot_valid_reg;

endmodule

/* File: hw/ebpfg_pkg.sv */
// package for the eight-bit port f block: offsets, masks, reset values
// assumes a 32-bit apb master and word-aligned byte addresses

package ebpfg_pkg;

    // ------------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------------
    localparam int unsigned PORT_W   = 8;
    localparam int unsigned ADDR_W   = 8;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned SYNC_LEN = 2;
    localparam int unsigned STRAP_BIT = 0;

    // ------------------------------------------------------------------
    // register byte offsets from the port base
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_DATA = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_FR1  = 8'h08;
    localparam logic [7:0] OFS_FR2  = 8'h0c;
    localparam logic [7:0] OFS_FR3  = 8'h10;
    localparam logic [7:0] OFS_OD   = 8'h28;
    localparam logic [7:0] OFS_PUP  = 8'h2c;
    localparam logic [7:0] OFS_IE   = 8'h38;

    // ------------------------------------------------------------------
    // implemented bits of each register, others read zero
    // ------------------------------------------------------------------
    localparam logic [7:0] MASK_ALL = 8'hff;
    localparam logic [7:0] MASK_FR1 = 8'hfe;
    localparam logic [7:0] MASK_FR2 = 8'h30;
    localparam logic [7:0] MASK_FR3 = 8'h31;
    localparam logic [7:0] MASK_IE  = 8'hfe;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_PUP  = 8'h01;
    localparam logic [7:0] IBE_HELD = 8'h01;
    localparam logic [1:0] ALIGN_OK = 2'h0;

    typedef enum logic {
        PH_HELD,
        PH_RUN
    } ebpfg_phase_t;

endpackage

/* File: hw/ebpfg_pin_cell.sv */
// one pad slice: input synchroniser and registered drive
// assumes pad_in is an asynchronous pin level

`timescale 1ns/10ps

module ebpfg_pin_cell #(
    parameter int unsigned SYNC_LEN = ebpfg_pkg::SYNC_LEN
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // pad side
    input  wire logic pad_in,
    output logic      pad_out,
    output logic      pad_oe,
    // core side
    input  wire logic drv_en,
    input  wire logic drv_val,
    input  wire logic od_sel,
    output logic      pin_lvl
);

    logic [SYNC_LEN-1:0] sync_reg;

    generate
        if (SYNC_LEN < 2) begin : g_chk
            $error("ebpfg_pin_cell: SYNC_LEN below 2");
        end
    endgenerate

    // ------------------------------------------------------------------
    // synchroniser, first stage feeds only the second
    // ------------------------------------------------------------------
    // no reset: the boot strap must pass through while reset is held
    always_ff @(posedge clk) begin
        sync_reg <= {sync_reg[SYNC_LEN-2:0], pad_in};
    end

    assign pin_lvl = sync_reg[SYNC_LEN-1];

    // ------------------------------------------------------------------
    // drive: open drain only pulls low, never drives a one
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            pad_out <= 1'b0;
            pad_oe  <= 1'b0;
        end else begin
            pad_out <= od_sel ? 1'b0 : drv_val;
            pad_oe  <= drv_en & (~od_sel | ~drv_val);
        end
    end

endmodule

/* File: tb/ebpfg_top_monitor.sv */
// port f checker: relations between the top module's ports
// assumes one clock, bound onto every instance of ebpfg_top

`timescale 1ns/10ps

module ebpfg_top_monitor (
    // clock and reset
    input wire logic        MCLK,
    input wire logic        SYS_RST,
    // apb
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    // pads and status
    input wire logic [7:0]  PF_IN,
    input wire logic [7:0]  PF_OE,
    input wire logic [7:0]  PF_PU,
    input wire logic [7:0]  PF_IBE,
    input wire logic        STOP_MODE,
    input wire logic [7:0]  INT_LINE,
    input wire logic        BOOT_FLASH,
    input wire logic        BOOT_VALID
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (SYS_RST);

    zero_wait_a: assert property (PREADY)
        else $error("slave not ready");
    upper_zero_a: assert property (PRDATA[31:8] == 24'h0)
        else $error("read data upper bits set");
    reset_pads_a: assert property ($fell(SYS_RST) |->
        PF_OE == 8'h00 && PF_PU == 8'h01 && PF_IBE == 8'h01)
        else $error("pad controls wrong in reset");
    out_only_a: assert property (!$past(SYS_RST) |->
        PF_IBE[0] == 1'b0)
        else $error("bit 0 input enabled in run");
    boot_hold_a: assert property ($fell(SYS_RST) |=>
        BOOT_VALID ##1 $stable(BOOT_FLASH)[*4])
        else $error("boot mode not latched");
    stop_quiet_a: assert property (STOP_MODE |=>
        INT_LINE == 8'h00)
        else $error("interrupt line active in stop");
    int_follow_a: assert property ((!STOP_MODE &&
        $stable(PF_IN) && $stable(PF_IBE))[*4] |->
        INT_LINE == (PF_IN & PF_IBE))
        else $error("interrupt line not following pin");
    err_phase_a: assert property (PSLVERR |-> PSEL && PENABLE)
        else $error("error outside access phase");
    reserved_a: assert property (PSEL && !PENABLE &&
        (PADDR == 8'h14 || PADDR[1:0] != 2'h0) ##1 PENABLE |->
        PSLVERR && PRDATA == 32'h0)
        else $error("reserved access not refused");
endmodule

bind ebpfg_top ebpfg_top_monitor i_ebpfg_top_monitor (
    .MCLK(MCLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PF_IN(PF_IN), .PF_OE(PF_OE), .PF_PU(PF_PU), .PF_IBE(PF_IBE),
    .STOP_MODE(STOP_MODE), .INT_LINE(INT_LINE),
    .BOOT_FLASH(BOOT_FLASH), .BOOT_VALID(BOOT_VALID));

/* File: tb/ebpfg_pad_model.sv */
// pad ring and board model for port f
// assumes device drive beats board drive; bare pins float

`timescale 1ns/10ps

module ebpfg_pad_model (
    // clock
    input  wire logic       clk,
    // device side
    input  wire logic [7:0] pad_out,
    input  wire logic [7:0] pad_oe,
    input  wire logic [7:0] pad_pu,
    // board side
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] pin_lvl
);
    logic [7:0] float_reg = 8'h5a;

    // a floating pin never holds its last level
    always_ff @(posedge clk) begin
        float_reg <= ~float_reg;
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pad_oe[i])
                pin_lvl[i] = pad_out[i];
            else if (ext_en[i])
                pin_lvl[i] = ext_val[i];
            else if (pad_pu[i])
                pin_lvl[i] = 1'b1;
            else
                pin_lvl[i] = float_reg[i];
        end
    end
endmodule

/* File: tb/ebpfg_top_tb.sv */
// self-checking bench for the port f block over apb
// assumes the pad model stands for the board and pins

`timescale 1ns/10ps

module ebpfg_top_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hf;
    logic [31:0] prdata, rd_val;
    logic        pready, pslverr, boot_flash, boot_valid, rd_err;
    logic        stop = 1'b0;
    logic [7:0]  pf_in, pf_out, pf_oe, pf_pu, pf_ibe, int_line, tmr_in;
    logic [7:0]  bus_out = 8'h00, bus_oe = 8'h00;
    logic [7:0]  ext_en = 8'hfe, ext_val = 8'h00;
    logic [7:0]  ofs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h28,
                             8'h2c, 8'h38};
    logic [7:0]  rst_v [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                               8'h01, 8'h00};
    logic [7:0]  ones_v [8] = '{8'hff, 8'hff, 8'hfe, 8'h30, 8'h31,
                                8'hff, 8'hff, 8'hfe};
    int          failures = 0;
    int          n_checks = 0;

    always #5 clk = ~clk;

    ebpfg_top i_ebpfg_top (
        .MCLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .PF_IN(pf_in), .PF_OUT(pf_out), .PF_OE(pf_oe), .PF_PU(pf_pu),
        .PF_IBE(pf_ibe), .ALT_BUS_OUT(bus_out), .ALT_BUS_OE(bus_oe),
        .STOP_MODE(stop), .INT_LINE(int_line), .TMR_IN(tmr_in),
        .BOOT_FLASH(boot_flash), .BOOT_VALID(boot_valid));

    ebpfg_pad_model i_ebpfg_pad_model (
        .clk(clk), .pad_out(pf_out), .pad_oe(pf_oe), .pad_pu(pf_pu),
        .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pf_in));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic final_report;
        $display("checks %0d, failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h, expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd_val = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hf);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 4'hf);
        chk(rd_val, exp);
    endtask

    // outputs settle a few edges after a write or pin change
    task automatic settle;
        repeat (4) @(posedge clk);
        #1;
    endtask

    task automatic do_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        settle();
    endtask

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        do_reset();
        chk({30'h0, boot_valid, boot_flash}, 32'h3);
        chk({pf_oe, pf_pu, pf_ibe, int_line}, 32'h0001_0000);
        $display("test reset done");
        // registers one at a time, so no two selects overlap
        for (int i = 0; i < 8; i++) begin
            rd(ofs[i], {24'h0, rst_v[i]});
            wr(ofs[i], 32'hffff_ffff);
            rd(ofs[i], {24'h0, ones_v[i]});
            wr(ofs[i], {24'h0, rst_v[i]});
        end
        $display("test registers done");
        rd(8'h14, 32'h0);
        chk({31'h0, rd_err}, 32'h1);
        rd(8'h02, 32'h0);
        chk({31'h0, rd_err}, 32'h1);
        apb(1'b1, 8'h04, 32'hff, 4'he);
        rd(8'h04, 32'h0);
        $display("test refusals done");
        wr(8'h04, 32'h02);
        wr(8'h00, 32'h02);
        settle();
        chk({pf_oe, pf_out}, 32'h0202);
        wr(8'h28, 32'h02);
        wr(8'h00, 32'h00);
        settle();
        chk({pf_oe, pf_out}, 32'h0200);
        wr(8'h00, 32'h02);
        settle();
        chk({pf_oe, pf_out}, 32'h0000);
        rd(8'h00, 32'h02);
        wr(8'h28, 32'h00);
        wr(8'h04, 32'h00);
        wr(8'h00, 32'h00);
        $display("test drive done");
        ext_val <= 8'ha0;
        wr(8'h38, 32'ha0);
        wr(8'h2c, 32'h04);
        settle();
        rd(8'h00, 32'ha0);
        chk({pf_ibe, pf_pu, int_line}, 32'ha004a0);
        wr(8'h10, 32'h20);
        settle();
        chk({tmr_in, int_line}, 32'h20a0);
        @(posedge clk) stop <= 1'b1;
        settle();
        chk({24'h0, int_line}, 32'h0);
        @(posedge clk) stop <= 1'b0;
        wr(8'h10, 32'h00);
        wr(8'h38, 32'h00);
        $display("test inputs done");
        bus_out <= 8'h02;
        bus_oe <= 8'h02;
        wr(8'h08, 32'h02);
        settle();
        chk({pf_oe, pf_out}, 32'h0202);
        wr(8'h08, 32'h00);
        settle();
        chk({24'h0, pf_oe}, 32'h0);
        $display("test alternate done");
        @(posedge clk);
        ext_en <= 8'hff;
        ext_val <= 8'h00;
        do_reset();
        chk({30'h0, boot_valid, boot_flash}, 32'h2);
        $display("test strap done");
        final_report();
    end

    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        final_report();
    end
endmodule
